/* rtl/wwt_regs.svh */
`ifndef WWT_REGS_SVH
`define WWT_REGS_SVH

// register indices as printed; byte address is four times the index
`define WWT_CTRL_IDX       10'h000
`define WWT_STATUS_IDX     10'h001
`define WWT_CTRL_ADDR      {`WWT_CTRL_IDX, 2'b00}
`define WWT_STATUS_ADDR    {`WWT_STATUS_IDX, 2'b00}

// field positions
`define WWT_OPEN_LSB       0
`define WWT_CLOSED_LSB     4
`define WWT_FIELD_W        4
`define WWT_LOCK_BIT       7
`define WWT_BUSY_BIT       0

// reset values
`define WWT_CTRL_RST       8'h00
`define WWT_STATUS_RST     8'h00
`define WWT_LOCK_RST       1'b0
`define WWT_CNT_RST        14'h0000

// span encoding: code n selects 2**(n+2) tick cycles
`define WWT_CODE_OFF       4'h0
`define WWT_CODE_MAX       4'hb
`define WWT_CODE_SHIFT     5'h02

// tick edges needed to carry a request into the tick domain
`define WWT_SYNC_TICKS     2'h2

`endif

/* rtl/wwt_pkg.sv */
package wwt_pkg;

  typedef enum logic [1:0]
  {
    WWT_OFF,
    WWT_FIRST,
    WWT_CLOSED,
    WWT_OPEN
  } wwt_state_type;

  typedef logic [13:0] wwt_count_type;

endpackage

/* rtl/wwt_tick_if.sv */
interface wwt_tick_if;
  logic tick;

  modport src
  (
    output tick
  );

  modport dst
  (
    input  tick
  );
endinterface

/* rtl/wwt_tick_sync.sv */
module wwt_tick_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic wd_tick_clock,
  wwt_tick_if.src   tk
);

  logic sync1_r;
  logic sync2_r;
  logic last_r;

  ////////////////////////////////////////////////////////////////////////////
  // the slow oscillator is asynchronous, so it is sampled twice first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r  <= 1'b0;
    end
    else if (ce)
    begin
      sync1_r <= wd_tick_clock;
      sync2_r <= sync1_r;
      last_r  <= sync2_r;
    end
  end

  // one pclk pulse per rising edge of the tick clock
  assign tk.tick = ce & sync2_r & ~last_r;

endmodule

/* rtl/wwt_watchdog.sv */
// Design decision made here: register access over APB.
`include "wwt_regs.svh"

// Contract
// - debug halt clears the counter
// - after halt, window mode runs open period first
// - nonzero timeout code enables the watchdog
// - zero closed code normal, nonzero window mode
// - normal mode resets on timeout, restart renews
// - restart in closed span resets at once
// - open follows closed; open expiry resets
// - first closed span waits for first restart
// - restart synchronised in ticks; extras ignored
// - lock sets only, clears in debug, freezes control
// - control from fuse; enabled fuse sets lock
// - protected writes need the unlock window
// - guarded-out writes complete, change nothing
// - control writes cross to tick domain, busy
// - runs in sleep while tick runs
// - run-time debug without halt changes nothing
// - closed code bits 7:4, doubling from 8
// - timeout code bits 3:0, doubling from 8
// - counter advances on slow tick clock
// - busy flag read-only, cleared by hardware
module wwt_watchdog
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wd_tick_clock,
  input  wire logic        cpu_halted,
  input  wire logic        debug_mode,
  input  wire logic        change_guard_open,
  input  wire logic        restart_request_instr,
  input  wire logic [7:0]  boot_config_fuse,
  output logic             system_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  wwt_tick_if tk_if ();

  logic [7:0]             ctrl_r;
  logic [7:0]             act_r;
  logic                   lock_r;
  logic                   busy_r;
  logic [1:0]             busy_cnt_r;
  logic                   boot_done_r;
  logic                   rs_pend_r;
  logic [1:0]             rs_cnt_r;
  wwt_pkg::wwt_state_type state_r;
  wwt_pkg::wwt_state_type state_nxt;
  wwt_pkg::wwt_count_type cnt_r;
  wwt_pkg::wwt_count_type cnt_nxt;
  logic                   wd_reset_r;
  logic                   wd_reset_nxt;
  logic [31:0]            prdata_r;
  logic                   pready_r;
  logic                   pslverr_r;

  wire logic              tick;
  wire logic              apb_access;
  wire logic              apb_commit;
  wire logic              sel_ctrl;
  wire logic              sel_status;
  wire logic              sel_hit;
  wire logic              wr_ctrl;
  wire logic              wr_status;
  wire logic              ctrl_take;
  wire logic              lock_set;
  wire logic              lock_clr;
  wire logic [7:0]        status_val;
  wire logic [31:0]       rdata;
  wire logic              cfg_apply;
  wire logic              rs_take;
  wire logic              rs_done;
  wire logic              act_en;
  wire logic              act_win;
  wire logic              new_en;
  wire logic              new_win;
  wwt_pkg::wwt_count_type lim_m1 [2];
  wwt_pkg::wwt_count_type span_m1;
  wire logic              span_end;

  ////////////////////////////////////////////////////////////////////////////
  // tick clock edge detection

  wwt_tick_sync u_tick_sync
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .ce            (ce),
    .wd_tick_clock (wd_tick_clock),
    .tk            (tk_if.src)
  );

  assign tick = tk_if.tick;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign apb_access = psel & penable;
  assign apb_commit = apb_access & pready_r;
  assign sel_ctrl   = (paddr == `WWT_CTRL_ADDR);
  assign sel_status = (paddr == `WWT_STATUS_ADDR);
  assign sel_hit    = sel_ctrl | sel_status;
  assign wr_ctrl    = apb_commit & pwrite & sel_ctrl;
  assign wr_status  = apb_commit & pwrite & sel_status;

  // a write while busy is dropped, keeping the pending transfer coherent
  assign ctrl_take  = wr_ctrl & change_guard_open & ~lock_r & ~busy_r & boot_done_r;
  assign lock_set   = wr_status & change_guard_open & pwdata[`WWT_LOCK_BIT];
  assign lock_clr   = wr_status & change_guard_open & debug_mode
                    & ~pwdata[`WWT_LOCK_BIT];

  assign status_val = {lock_r, 6'h00, busy_r};
  assign rdata      = sel_ctrl   ? {24'h000000, ctrl_r}     :
                      sel_status ? {24'h000000, status_val} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // span lengths, one per field

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_span
      wire logic [3:0] code;
      wire logic [3:0] code_c;
      wire logic [4:0] shamt;
      assign code   = act_r[gi*`WWT_FIELD_W +: `WWT_FIELD_W];
      // reserved codes take the longest span rather than disabling the dog
      assign code_c = (code > `WWT_CODE_MAX) ? `WWT_CODE_MAX : code;
      assign shamt  = {1'b0, code_c} + `WWT_CODE_SHIFT;
      assign lim_m1[gi] = (14'h0001 << shamt) - 14'h0001;
    end
  endgenerate

  assign act_en   = act_r[`WWT_OPEN_LSB +: `WWT_FIELD_W] != `WWT_CODE_OFF;
  assign act_win  = act_r[`WWT_CLOSED_LSB +: `WWT_FIELD_W] != `WWT_CODE_OFF;
  assign new_en   = ctrl_r[`WWT_OPEN_LSB +: `WWT_FIELD_W] != `WWT_CODE_OFF;
  assign new_win  = ctrl_r[`WWT_CLOSED_LSB +: `WWT_FIELD_W] != `WWT_CODE_OFF;

  assign span_m1  = (state_r == wwt_pkg::WWT_CLOSED) ? lim_m1[1] : lim_m1[0];
  assign span_end = (cnt_r == span_m1);

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the tick domain

  assign cfg_apply = busy_r & tick & (busy_cnt_r == `WWT_SYNC_TICKS - 2'h1);
  assign rs_take   = restart_request_instr & ~rs_pend_r;
  assign rs_done   = rs_pend_r & tick & (rs_cnt_r == `WWT_SYNC_TICKS - 2'h1);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end
    else if (ce)
    begin
      pready_r  <= apb_access & ~pready_r;
      pslverr_r <= apb_access & ~pready_r & ~sel_hit;
      if (apb_access & ~pready_r)
      begin
        prdata_r <= rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register, boot load and lock

  // fuse is caught on the first enabled edge after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_done_r <= 1'b0;
      ctrl_r      <= `WWT_CTRL_RST;
      lock_r      <= `WWT_LOCK_RST;
    end
    else if (ce)
    begin
      boot_done_r <= 1'b1;
      if (!boot_done_r)
      begin
        ctrl_r <= boot_config_fuse;
        lock_r <= boot_config_fuse[`WWT_OPEN_LSB +: `WWT_FIELD_W] != `WWT_CODE_OFF;
      end
      else
      begin
        if (ctrl_take)
        begin
          ctrl_r <= pwdata[7:0];
        end
        if (lock_set)
        begin
          lock_r <= 1'b1;
        end
        else if (lock_clr)
        begin
          lock_r <= 1'b0;
        end
      end
    end
  end

  // control value travels to the counter after two tick edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_r     <= 1'b0;
      busy_cnt_r <= 2'h0;
      act_r      <= `WWT_CTRL_RST;
    end
    else if (ce)
    begin
      if (!boot_done_r || ctrl_take)
      begin
        busy_r     <= 1'b1;
        busy_cnt_r <= 2'h0;
      end
      else if (cfg_apply)
      begin
        busy_r <= 1'b0;
        act_r  <= ctrl_r;
      end
      else if (busy_r && tick)
      begin
        busy_cnt_r <= busy_cnt_r + 2'h1;
      end
    end
  end

  // restart request; a second one while pending is dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rs_pend_r <= 1'b0;
      rs_cnt_r  <= 2'h0;
    end
    else if (ce)
    begin
      if (rs_take)
      begin
        rs_pend_r <= 1'b1;
        rs_cnt_r  <= 2'h0;
      end
      else if (rs_done)
      begin
        rs_pend_r <= 1'b0;
      end
      else if (rs_pend_r && tick)
      begin
        rs_cnt_r <= rs_cnt_r + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and window sequencer
  // no sleep input exists and debug_mode never reaches the counter: only a halt or a zero timeout code stops the dog

  always_comb
  begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    wd_reset_nxt = wd_reset_r;
    if (wd_reset_r)
    begin
      // reset request holds until the system reset clears this block
      state_nxt = state_r;
    end
    else if (cpu_halted)
    begin
      cnt_nxt   = `WWT_CNT_RST;
      // on resume an open period runs before any closed span
      state_nxt = act_en ? wwt_pkg::WWT_FIRST : wwt_pkg::WWT_OFF;
    end
    else if (cfg_apply)
    begin
      if (!new_en)
      begin
        state_nxt = wwt_pkg::WWT_OFF;
        cnt_nxt   = `WWT_CNT_RST;
      end
      else if (state_r == wwt_pkg::WWT_OFF || (new_win && !act_win))
      begin
        state_nxt = wwt_pkg::WWT_FIRST;
        cnt_nxt   = `WWT_CNT_RST;
      end
      else if (!new_win && state_r == wwt_pkg::WWT_CLOSED)
      begin
        state_nxt = wwt_pkg::WWT_OPEN;
        cnt_nxt   = `WWT_CNT_RST;
      end
    end
    else if (rs_done && state_r != wwt_pkg::WWT_OFF)
    begin
      cnt_nxt = `WWT_CNT_RST;
      if (state_r == wwt_pkg::WWT_CLOSED)
      begin
        wd_reset_nxt = 1'b1;
      end
      else if (act_win)
      begin
        state_nxt = wwt_pkg::WWT_CLOSED;
      end
      else
      begin
        state_nxt = wwt_pkg::WWT_OPEN;
      end
    end
    else if (tick && state_r != wwt_pkg::WWT_OFF)
    begin
      if (!span_end)
      begin
        cnt_nxt = cnt_r + 14'h0001;
      end
      else
      begin
        case (state_r)
          wwt_pkg::WWT_CLOSED:
          begin
            state_nxt = wwt_pkg::WWT_OPEN;
            cnt_nxt   = `WWT_CNT_RST;
          end
          wwt_pkg::WWT_FIRST,
          wwt_pkg::WWT_OPEN:
          begin
            wd_reset_nxt = 1'b1;
          end
          default:
          begin
            state_nxt = wwt_pkg::WWT_OFF;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= wwt_pkg::WWT_OFF;
      cnt_r      <= `WWT_CNT_RST;
      wd_reset_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      wd_reset_r <= wd_reset_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign system_reset_req = wd_reset_r;

endmodule

/* tb/wwt_watchdog_chk.sv */
module wwt_watchdog_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_halted,
  input wire logic        system_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && !pready;
  wire hit = paddr == 12'h000 || paddr == 12'h004;
  //////////////////////////////
  property p_rdy; acc |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && !hit; endproperty
  property p_ok; acc && hit |=> !pslverr; endproperty
  property p_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  property p_sticky; system_reset_req |=> system_reset_req; endproperty
  // two halted edges first: halt outranks an expiry on the same edge, so none lands
  property p_halt;
    cpu_halted && $past(cpu_halted) && $past(cpu_halted, 2) |=> $stable(system_reset_req);
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready missing after access");
  a_pulse: assert property (p_pulse)
    else $error("ready held too long");
  a_err: assert property (p_err)
    else $error("error on mapped address");
  a_ok: assert property (p_ok)
    else $error("error on mapped access");
  a_zero: assert property (p_zero)
    else $error("data on refused access");
  a_upper: assert property (p_upper)
    else $error("upper read bits set");
  a_sticky: assert property (p_sticky)
    else $error("reset request dropped");
  a_halt: assert property (p_halt)
    else $error("reset request during halt");
  c_rst: cover property ($rose(system_reset_req));
  c_err: cover property (pslverr);
  c_halt: cover property (cpu_halted ##1 !cpu_halted);
endmodule

bind wwt_watchdog wwt_watchdog_chk i_wwt_watchdog_chk
(
  .pclk             (pclk),
  .presetn          (presetn),
  .psel             (psel),
  .penable          (penable),
  .paddr            (paddr),
  .prdata           (prdata),
  .pready           (pready),
  .pslverr          (pslverr),
  .cpu_halted       (cpu_halted),
  .system_reset_req (system_reset_req)
);

/* tb/windowed_watchdog_timer_test.sv */
module windowed_watchdog_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed
  {
    logic g;
    logic [11:0] a;
    logic [7:0] d;
    logic [7:0] x;
    logic e;
  } wwt_row_type;
  localparam wwt_row_type rows [5] = '{
    '{1'b0, 12'h000, 8'h03, 8'h00, 1'b0},
    '{1'b1, 12'h000, 8'hb0, 8'hb0, 1'b0},
    '{1'b1, 12'h000, 8'h00, 8'h00, 1'b0},
    '{1'b1, 12'h004, 8'h01, 8'h00, 1'b0},
    '{1'b1, 12'h008, 8'h5a, 8'h00, 1'b1}};
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tick;
  logic        halt;
  logic        dbg;
  logic        guard;
  logic        rr;
  logic [7:0]  fuse;
  logic        srst;
  logic [31:0] rd;
  logic        er;
  int          num_errors;
  int          samples_checked;

  wwt_watchdog i_wwt_watchdog
  (
    .pclk                  (pclk),
    .presetn               (presetn),
    .ce                    (ce),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .wd_tick_clock         (tick),
    .cpu_halted            (halt),
    .debug_mode            (dbg),
    .change_guard_open     (guard),
    .restart_request_instr (rr),
    .boot_config_fuse      (fuse),
    .system_reset_req      (srst)
  );
  //////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // tick every 8 pclk keeps spans short
  initial
  begin
    tick = 1'b0;
    forever
    begin
      repeat (4) @(posedge pclk);
      tick <= ~tick;
    end
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    finish_test;
  end
  //////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    guard <= 1'b1;
    apb(1'b1, a, d);
    guard <= 1'b0;
  endtask
  // control writes while busy are dropped, so always wait here
  task automatic sync;
    do
      apb(1'b0, 12'h004, 8'h00);
    while (rd[0] !== 1'b0);
  endtask
  task automatic kick;
    @(posedge pclk);
    rr <= 1'b1;
    @(posedge pclk);
    rr <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n * 8) @(posedge pclk);
  endtask
  task automatic rst(input logic [7:0] f);
    fuse <= f;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(srst, 1'b0);
    sync;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    cmp(rd, {24'h0, x});
  endtask
  task finish_test;
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////
  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    {presetn, psel, penable, pwrite, halt, dbg, guard, rr} = 8'h00;
    {paddr, pwdata, fuse} = 52'h0;
    ce = 1'b1;
    rst(8'h00);
    rdc(12'h000, 8'h00);
    rdc(12'h004, 8'h00);
    foreach (rows[i])
    begin
      guard <= rows[i].g;
      apb(1'b1, rows[i].a, rows[i].d);
      guard <= 1'b0;
      chk(er, rows[i].e);
      sync;
      rdc(rows[i].a, rows[i].x);
    end
    wr(12'h000, 8'h01);
    sync;
    repeat (6)
    begin
      kick;
      wt(4);
    end
    wt(3);
    chk(srst, 1'b0);
    wt(7);
    chk(srst, 1'b1);
    rst(8'h00);
    wr(12'h000, 8'h12);
    sync;
    kick;
    wt(12);
    kick;
    wt(12);
    kick;
    wt(4);
    chk(srst, 1'b0);
    kick;
    wt(6);
    chk(srst, 1'b1);
    rst(8'h00);
    wr(12'h000, 8'h11);
    sync;
    kick;
    wt(2);
    halt <= 1'b1;
    wt(25);
    chk(srst, 1'b0);
    halt <= 1'b0;
    kick;
    wt(5);
    chk(srst, 1'b0);
    wt(20);
    chk(srst, 1'b1);
    rst(8'h0b);
    rdc(12'h000, 8'h0b);
    rdc(12'h004, 8'h80);
    wr(12'h000, 8'h00);
    sync;
    rdc(12'h000, 8'h0b);
    dbg <= 1'b1;
    wr(12'h004, 8'h00);
    dbg <= 1'b0;
    rdc(12'h004, 8'h00);
    wr(12'h000, 8'h00);
    sync;
    rdc(12'h000, 8'h00);
    wr(12'h004, 8'h80);
    rdc(12'h004, 8'h80);
    // enable low must hold every register as it was
    @(posedge pclk);
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    ce <= 1'b1;
    rdc(12'h004, 8'h80);
    chk(srst, 1'b0);
    finish_test;
  end
endmodule
